// ==== rtl/ltir_consts.vh ====
// Constants for the light threshold interrupt reporting block
`ifndef LTIR_CONSTS_VH
`define LTIR_CONSTS_VH

// Width of result and limit words
`define LTIR_DATA_W 16
// Low limit top bits: position and end-of-conversion code
`define LTIR_LOW_TOP_HI 15
`define LTIR_LOW_TOP_LO 14
`define LTIR_EOC_CODE 2'h3

// Conversion mode field code for shutdown
`define LTIR_MODE_SHUTDOWN 2'h0

// Fault count field codes
`define LTIR_FC_ONE 2'h0
`define LTIR_FC_TWO 2'h1
`define LTIR_FC_FOUR 2'h2
`define LTIR_FC_EIGHT 2'h3

// Consecutive run counter and the counts each code selects
`define LTIR_RUN_W 4
`define LTIR_RUN_ZERO 4'h0
`define LTIR_RUN_ONE 4'h1
`define LTIR_RUN_TWO 4'h2
`define LTIR_RUN_FOUR 4'h4
`define LTIR_RUN_EIGHT 4'h8

// Outcome of one comparison
`define LTIR_OUT_NONE 2'h0
`define LTIR_OUT_HIGH 2'h1
`define LTIR_OUT_LOW 2'h2

// Single-bit clear and set values
`define LTIR_BIT_CLR 1'h0
`define LTIR_BIT_SET 1'h1

// Flag pair: number of sides and the index of each side
`define LTIR_NUM_SIDES 2
`define LTIR_SIDE_HIGH 0
`define LTIR_SIDE_LOW 1

`endif

// ==== rtl/ltir_irq.v ====
// Light sensor threshold comparison and interrupt reporting logic
`timescale 1ns/1ps
`include "ltir_consts.vh"

////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////

// Limitations:
// Result and limits are compared as plain unsigned words; their
// scaled encoding is handled outside this block.
// Leaving end-of-conversion reporting with the latch field at 0 may
// keep the line active until the latch field is toggled.
// Read, write and alert arrive as one-cycle pulses from the bus engine.
// All state, the pin included, freezes while ce is low.

module ltir_irq (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire conv_done,
    input wire [`LTIR_DATA_W-1:0] result,
    input wire [`LTIR_DATA_W-1:0] high_limit,
    input wire [`LTIR_DATA_W-1:0] low_limit,
    input wire latch_field,
    input wire irq_polarity_field,
    input wire [1:0] fault_count_field,
    input wire cfg_read,
    input wire cfg_write,
    input wire [1:0] cfg_wr_mode,
    input wire alert_resp,
    output reg flag_high,
    output reg flag_low,
    output reg conv_ready,
    output reg int_active,
    output reg int_o,
    output reg int_oe
);

////////////////////////////////////////////////////////////////////////////
// Comparison and fault qualification

wire [1:0] low_limit_top_bits;
wire eoc_mode;
wire [1:0] outcome;
reg [1:0] prev_outcome;
reg [`LTIR_RUN_W-1:0] run_len;
reg [`LTIR_RUN_W-1:0] next_run_len;
reg [`LTIR_RUN_W-1:0] run_needed;
wire qualified;
wire qual_high;
wire qual_low;

assign low_limit_top_bits =
    low_limit[`LTIR_LOW_TOP_HI:`LTIR_LOW_TOP_LO];
assign eoc_mode = (low_limit_top_bits == `LTIR_EOC_CODE);

// Limits compared as plain unsigned words; the host must keep
// high above low or a result between the two is reported as high only.
wire above_high;
wire below_low;

assign above_high = (result > high_limit);
assign below_low = (result < low_limit);
assign outcome = above_high ? `LTIR_OUT_HIGH :
                 below_low ? `LTIR_OUT_LOW :
                 `LTIR_OUT_NONE;

always @* begin
    case (fault_count_field)
        `LTIR_FC_ONE: run_needed = `LTIR_RUN_ONE;
        `LTIR_FC_TWO: run_needed = `LTIR_RUN_TWO;
        `LTIR_FC_FOUR: run_needed = `LTIR_RUN_FOUR;
        `LTIR_FC_EIGHT: run_needed = `LTIR_RUN_EIGHT;
        default: run_needed = `LTIR_RUN_ONE;
    endcase
end

// Run length saturates at the largest count so it never wraps
always @* begin
    next_run_len = run_len;
    if (conv_done) begin
        if (outcome == `LTIR_OUT_NONE) begin
            next_run_len = `LTIR_RUN_ZERO;
        end else if (outcome != prev_outcome) begin
            next_run_len = `LTIR_RUN_ONE;
        end else if (run_len != `LTIR_RUN_EIGHT) begin
            next_run_len = run_len + `LTIR_RUN_ONE;
        end
    end
end

// Every conversion inside a long enough run qualifies again
assign qualified = conv_done && (outcome != `LTIR_OUT_NONE) &&
                   (next_run_len >= run_needed);
assign qual_high = qualified && (outcome == `LTIR_OUT_HIGH);
assign qual_low = qualified && (outcome == `LTIR_OUT_LOW);

always @(posedge clk) begin
    if (rst) begin
        run_len <= `LTIR_RUN_ZERO;
    end else if (ce) begin
        run_len <= next_run_len;
    end
end

// Outcome is remembered only when a conversion lands
always @(posedge clk) begin
    if (rst) begin
        prev_outcome <= `LTIR_OUT_NONE;
    end else if (ce && conv_done) begin
        prev_outcome <= outcome;
    end
end

////////////////////////////////////////////////////////////////////////////
// Event decode

// Clears and sets are decoded apart; the sets are applied last so an
// event landing in the same cycle as a clear is never lost
wire cfg_run_write;
wire read_clears_flags;
wire alert_taken;
wire ready_clear;
wire int_clear;
wire int_set;
wire int_drop;
wire [`LTIR_NUM_SIDES-1:0] qual_side;
wire [`LTIR_NUM_SIDES-1:0] flag_now;
wire [`LTIR_NUM_SIDES-1:0] next_flag_vec;
wire next_int_oe;
reg next_conv_ready;
reg next_int_active;

// Shutdown writes fall through untouched
assign cfg_run_write = cfg_write &&
    (cfg_wr_mode != `LTIR_MODE_SHUTDOWN);

// Latched comparison forgets both sides on a configuration read
assign read_clears_flags = cfg_read && latch_field;

// Transparent mode does not answer the alert response at all
assign alert_taken = alert_resp && latch_field;

// Every read and every running write drop conversion ready
assign ready_clear = cfg_read || cfg_run_write;

// Transparent comparison keeps the line through configuration access;
// only end-of-conversion reporting is released by it there
assign int_clear = (cfg_read && latch_field) ||
    (cfg_read && eoc_mode) ||
    (cfg_run_write && !latch_field && eoc_mode) ||
    alert_taken;

// End-of-conversion reporting raises the line on every conversion
assign int_set = conv_done &&
    (eoc_mode || qual_high || (latch_field && qual_low));

// A transparent low run releases the line unless EOC reporting owns it
assign int_drop = conv_done && !latch_field && !eoc_mode &&
    qual_low;

////////////////////////////////////////////////////////////////////////////
// Flag pair, one slice per side: high first, then low

assign qual_side[`LTIR_SIDE_HIGH] = qual_high;
assign qual_side[`LTIR_SIDE_LOW] = qual_low;
assign flag_now[`LTIR_SIDE_HIGH] = flag_high;
assign flag_now[`LTIR_SIDE_LOW] = flag_low;

// Both flags share one rule shape, mirrored between the sides
genvar side;
generate
    for (side = 0; side < `LTIR_NUM_SIDES; side = side + 1) begin : g_side
        wire set_side;
        wire drop_side;

        // A qualified run on this side always raises its own flag
        assign set_side = conv_done && qual_side[side];

        // In transparent mode a run on the other side takes it down
        assign drop_side = conv_done && !latch_field &&
            qual_side[`LTIR_NUM_SIDES-1-side];

        // Set wins over a read clear of the same cycle
        assign next_flag_vec[side] =
            set_side ? `LTIR_BIT_SET :
            (drop_side || read_clears_flags) ? `LTIR_BIT_CLR :
            flag_now[side];
    end
endgenerate

////////////////////////////////////////////////////////////////////////////
// Conversion ready and logical interrupt state

// Ready is set by every conversion and dropped by reads and running writes
always @* begin
    next_conv_ready = conv_ready;
    if (ready_clear) begin
        next_conv_ready = `LTIR_BIT_CLR;
    end
    if (conv_done) begin
        next_conv_ready = `LTIR_BIT_SET;
    end
end

// Clears first, then the conversion decides
always @* begin
    next_int_active = int_active;
    if (int_clear) begin
        next_int_active = `LTIR_BIT_CLR;
    end
    if (int_set) begin
        next_int_active = `LTIR_BIT_SET;
    end else if (int_drop) begin
        next_int_active = `LTIR_BIT_CLR;
    end
end

// Polarity is applied to the next state, so a polarity change alone
// reaches the pin at the next enabled clock
assign next_int_oe = next_int_active ^ irq_polarity_field;

////////////////////////////////////////////////////////////////////////////
// Reporting registers

// Flags keep their value through every non-qualified conversion
always @(posedge clk) begin
    if (rst) begin
        flag_high <= `LTIR_BIT_CLR;
    end else if (ce) begin
        flag_high <= next_flag_vec[`LTIR_SIDE_HIGH];
    end
end

always @(posedge clk) begin
    if (rst) begin
        flag_low <= `LTIR_BIT_CLR;
    end else if (ce) begin
        flag_low <= next_flag_vec[`LTIR_SIDE_LOW];
    end
end

// Ready reads back 1 once after a conversion, then 0
always @(posedge clk) begin
    if (rst) begin
        conv_ready <= `LTIR_BIT_CLR;
    end else if (ce) begin
        conv_ready <= next_conv_ready;
    end
end

// Logical state kept apart from the pin so polarity never touches it
always @(posedge clk) begin
    if (rst) begin
        int_active <= `LTIR_BIT_CLR;
    end else if (ce) begin
        int_active <= next_int_active;
    end
end

////////////////////////////////////////////////////////////////////////////
// Open-drain pin

// The data bit is always low; only the enable moves, so the line is
// either pulled low here or left to the external pull-up
always @(posedge clk) begin
    if (rst) begin
        int_o <= `LTIR_BIT_CLR;
    end else if (ce) begin
        int_o <= `LTIR_BIT_CLR;
    end
end

// Reset releases the line whatever the polarity setting
always @(posedge clk) begin
    if (rst) begin
        int_oe <= `LTIR_BIT_CLR;
    end else if (ce) begin
        int_oe <= next_int_oe;
    end
end

endmodule // ltir_irq

// ==== sim/ltir_host.sv ====
// Host side model: limit words and the pulled-up interrupt line
`timescale 1ns/1ps
module ltir_host (
    input wire int_o,
    input wire int_oe,
    input wire eoc_sel,
    output wire [15:0] high_limit,
    output wire [15:0] low_limit,
    output wire pin
);
    // Top bits 11 in the low word select end-of-conversion reporting
    assign high_limit = eoc_sel ? 16'hF000 : 16'h8000;
    assign low_limit = eoc_sel ? 16'hC000 : 16'h1000;
    // Pull-up wins whenever the device lets go of the line
    assign pin = int_oe ? int_o : 1'b1;
endmodule // ltir_host

// ==== sim/ltir_irq_properties.sv ====
// Port assertions for the threshold interrupt block
`timescale 1ns/1ps
module ltir_irq_chk (
    input wire clk, rst, ce, conv_done, latch_field, irq_polarity_field,
    input wire [15:0] result, high_limit, low_limit,
    input wire [1:0] fault_count_field, cfg_wr_mode,
    input wire cfg_read, cfg_write, alert_resp,
    input wire flag_high, flag_low, conv_ready, int_active, int_o, int_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire quiet = ce && !conv_done;
    wire cmp1 = ce && conv_done && fault_count_field == 2'h0
        && low_limit[15:14] != 2'h3;
    a_pin_polarity: assert property (
        $past(ce) && !$past(rst) |-> !int_o
        && int_oe == (int_active ^ $past(irq_polarity_field)))
        else $error("pin level wrong");
    a_high_run: assert property (cmp1 && result > high_limit |=>
        flag_high && int_active && ($past(latch_field) || !flag_low))
        else $error("high run not reported");
    a_low_run: assert property (cmp1 && result < low_limit |=>
        flag_low && ($past(latch_field) ? int_active :
        !flag_high && !int_active))
        else $error("low run not reported");
    a_conv_ready: assert property (ce && conv_done |=> conv_ready)
        else $error("ready not set");
    a_read_clear: assert property (quiet && cfg_read |=> !conv_ready
        && (!$past(latch_field) || !flag_high && !flag_low && !int_active))
        else $error("read clear wrong");
    a_write_effect: assert property (
        quiet && cfg_write && !cfg_read && !alert_resp |=>
        ($past(cfg_wr_mode) == 2'h0 ? $stable({flag_high, flag_low,
        conv_ready, int_active}) : !conv_ready))
        else $error("write effect wrong");
    a_alert_effect: assert property (
        quiet && alert_resp && !cfg_read && !cfg_write |=>
        $stable({flag_high, flag_low, conv_ready}) &&
        ($past(latch_field) ? !int_active : $stable(int_active)))
        else $error("alert effect wrong");
    a_transp_keep: assert property (
        quiet && !latch_field && low_limit[15:14] != 2'h3 && (cfg_read ||
        cfg_write) |=> $stable({flag_high, flag_low, int_active}))
        else $error("transparent state disturbed");
    a_ce_freeze: assert property (!ce |=> $stable({flag_high, flag_low,
        conv_ready, int_active, int_o, int_oe}))
        else $error("state moved while disabled");
endmodule // ltir_irq_chk
bind ltir_irq ltir_irq_chk i_chk (.*);

// ==== sim/tb_ltir_irq.sv ====
// Self-checking bench for the threshold interrupt block
`timescale 1ns/1ps
module tb_ltir_irq;
    reg clk = 0, rst = 1, ce = 1, conv_done = 0, latch_field = 1;
    reg irq_polarity_field = 0, cfg_read = 0, cfg_write = 0, alert_resp = 0;
    reg eoc_sel = 0;
    reg [15:0] result = 16'h0000;
    reg [1:0] fault_count_field = 2'h0, cfg_wr_mode = 2'h0;
    wire [15:0] high_limit, low_limit;
    wire flag_high, flag_low, conv_ready, int_active, int_o, int_oe, pin;
    integer num_errors = 0, cmp_count = 0;
    ltir_irq i_dut (.*);
    ltir_host i_host (.*);
    initial forever #50 clk = ~clk;
    // k = conversion, read, write, alert; write mode rides on r
    task go(input [3:0] k, input [15:0] r, input [4:0] e);
        begin
            @(posedge clk);
            {conv_done, cfg_read, cfg_write, alert_resp} <= k;
            result <= r;
            cfg_wr_mode <= r[1:0];
            @(posedge clk);
            {conv_done, cfg_read, cfg_write, alert_resp} <= 4'h0;
            #1;
            cmp_count = cmp_count + 1;
            if ({flag_high, flag_low, conv_ready, int_active, pin} !== e) begin
                num_errors = num_errors + 1;
                $display("unexpected at %0t: got %h expected %h", $time,
                    {flag_high, flag_low, conv_ready, int_active, pin}, e);
            end
        end
    endtask
    task end_of_test;
        begin
            $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
            if (num_errors == 0 && cmp_count > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    initial begin
        #200000;
        num_errors = num_errors + 1;
        end_of_test;
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 0;
        go(8, 16'h9000, 5'h16);
        go(4, 16'h0000, 5'h01);
        go(8, 16'h0800, 5'h0E);
        go(1, 16'h0000, 5'h0D);
        go(8, 16'h4000, 5'h0D);
        go(4, 16'h0000, 5'h01);
        go(4, 16'h0000, 5'h01);
        go(8, 16'h4000, 5'h05);
        go(2, 16'h0000, 5'h05);
        go(2, 16'h0003, 5'h01);
        $display("test latched done");
        @(posedge clk) latch_field <= 0;
        go(8, 16'h9000, 5'h16);
        go(4, 16'h0000, 5'h12);
        go(1, 16'h0000, 5'h12);
        go(8, 16'h0800, 5'h0D);
        $display("test transparent done");
        @(posedge clk) fault_count_field <= 2'h1;
        go(8, 16'h9000, 5'h0D);
        go(8, 16'h4000, 5'h0D);
        go(8, 16'h9000, 5'h0D);
        go(8, 16'h9000, 5'h16);
        $display("test fault count done");
        @(posedge clk) irq_polarity_field <= 1;
        fault_count_field <= 2'h0;
        go(8, 16'h9000, 5'h17);
        go(8, 16'h0800, 5'h0C);
        $display("test polarity done");
        @(posedge clk) ce <= 0;
        go(8, 16'h9000, 5'h0C);
        @(posedge clk) ce <= 1;
        go(8, 16'h9000, 5'h17);
        $display("test clock enable done");
        @(posedge clk) eoc_sel <= 1;
        latch_field <= 1;
        irq_polarity_field <= 0;
        go(4, 16'h0000, 5'h01);
        go(8, 16'hD000, 5'h06);
        go(2, 16'h0001, 5'h02);
        go(1, 16'h0000, 5'h01);
        @(posedge clk) latch_field <= 0;
        go(8, 16'hD000, 5'h06);
        go(2, 16'h0001, 5'h01);
        $display("test end of conversion done");
        end_of_test;
    end
endmodule // tb_ltir_irq
